// *** logic/cell_convergence_sublayer_params.svh ***
// constants for the atm cell convergence sublayer
`ifndef CELL_CONVERGENCE_SUBLAYER_PARAMS_SVH
`define CELL_CONVERGENCE_SUBLAYER_PARAMS_SVH

// cell geometry
`define CELL_LEN      53
`define HDR_LEN       4
`define HEC_POS       4
`define LAST_POS      52
`define HEC_COSET     8'h55
`define IDLE_HDR      32'h00000001
`define IDLE_PAYLOAD  8'h6a

// delineation thresholds
`define DELIN_ALPHA   7
`define DELIN_DELTA   6

// line frame and timing
`define CLK_MHZ       40
`define FRAME_MS      6
`define NTR_PARTS     48
`define NTR_PERIOD_NS 125000
`define NTR_CYCLES    ((`NTR_PERIOD_NS * `CLK_MHZ) / 1000)
`define N_MIN         3
`define N_MAX         36

// reference clock divisors to 8 khz
`define DIV_8K        1
`define DIV_64K       8
`define DIV_1544K     193
`define DIV_2048K     256

`endif

// *** logic/cell_convergence_sublayer_pkg.sv ***
// types shared by the atm cell convergence sublayer
package cell_convergence_sublayer_pkg;

    typedef enum logic [1:0] {
        ST_HUNT,
        ST_PRESYNC,
        ST_SYNC
    } delin_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } line_byte_s;

    typedef struct packed {
        logic       valid;
        logic       soc;
        logic [7:0] data;
    } atm_byte_s;

    typedef logic [1:0] ref_sel_t;

endpackage

// *** logic/hec_calc.sv ***
// header check byte: crc-8 x^8+x^2+x+1 over four header bytes, coset added
`include "cell_convergence_sublayer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module hec_calc (
    input  wire logic [31:0] i_hdr,
    output logic      [7:0]  o_hec
);
    logic [7:0] crc;

    always_comb
    begin
        crc = 8'h00;
        for (int k = 31; k >= 0; k--)
        begin
            if (crc[7] ^ i_hdr[k])
                crc = {crc[6:0], 1'b0} ^ 8'h07;
            else
                crc = {crc[6:0], 1'b0};
        end
        o_hec = crc ^ `HEC_COSET;
    end

endmodule

`default_nettype wire

// *** logic/atm_cell_convergence.sv ***
// atm cell convergence sublayer over the clear byte channel of a dsl payload
//
// Notes on behaviour
// - cells go in and out of the payload as continuous whole bytes
// - bytes are sent and assembled most significant bit first
// - cells start at any payload byte and may span line frames
// - at the line end with timing needed, stuffing is turned off
// - network end recovers 8 khz as 48 ticks per 6 ms frame
// - frame lasts 6 ms whatever the line rate
// - frame holds 48 times (1 + i + 8n) bits
// - payload block is i single bits then n bytes, n from 3 to 36
// - n gives 64 kbit/s channels, i gives 8 kbit/s channels
// - atm layer sends a cell only after transmit cell available
// - received cell handed over only after receive cell available
// - flow control keeps cell buffers from overflow and underflow
// - idle cells inserted when no cell is ready, removed on receive
// - idle cells carry and are recognised by the idle header pattern
// - header check byte computed per cell and xored with 01010101
// - header check covers every header byte
// - any check mismatch is a multibit error, never corrected
// - timing reference lines pass 8 khz between framing and atm layer
// - network reference is 8 khz or a selected multiple of it
// - payload scrambled with self-synchronising x^43+1, descrambled likewise
// - received idle cells never reach the atm layer
`include "cell_convergence_sublayer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module atm_cell_convergence #(
    parameter int NTR_CYCLES = `NTR_CYCLES
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_srst,
    input  wire cell_convergence_sublayer_pkg::atm_byte_s  i_tx,
    output logic                        o_tx_clav,
    input  wire logic                   i_rx_enb,
    output cell_convergence_sublayer_pkg::atm_byte_s       o_rx,
    output logic                        o_rx_clav,
    input  wire logic                   i_line_tx_req,
    output cell_convergence_sublayer_pkg::line_byte_s      o_line_tx,
    input  wire cell_convergence_sublayer_pkg::line_byte_s i_line_rx,
    output logic                        o_hec_err,
    output logic                        o_cell_sync,
    input  wire logic                   i_ltu_side,
    input  wire logic                   i_ntr_required,
    input  wire logic                   i_ref_clk,
    input  wire cell_convergence_sublayer_pkg::ref_sel_t   i_ref_sel,
    input  wire logic                   i_frame_sync,
    input  wire logic [5:0]             i_cfg_n,
    input  wire logic [2:0]             i_cfg_i,
    output logic                        o_stuffing_off,
    output logic                        o_transmit_timing_ref_line,
    output logic                        o_receive_timing_ref_line,
    output logic                        o_cfg_bad,
    output logic [13:0]                 o_frame_bits
);

    // ----------------------------------------------------------------
    // payload scrambler, one byte msb first
    // ----------------------------------------------------------------
    function automatic logic [50:0] scr8(input logic [42:0] st,
                                         input logic [7:0]  d,
                                         input logic        dsc);
        logic [42:0] s;
        logic [7:0]  o;
        s = st;
        o = 8'h00;
        for (int k = 7; k >= 0; k--)
        begin
            o[k] = d[k] ^ s[42];
            s    = {s[41:0], dsc ? d[k] : o[k]};
        end
        return {s, o};
    endfunction

    // ----------------------------------------------------------------
    // transmit path
    // ----------------------------------------------------------------
    logic [7:0]             tx_mem [0:`LAST_POS];
    logic                   tx_full_r, tx_full_nxt;
    logic                   tx_clav_r, tx_clav_nxt;
    logic [5:0]             tx_wptr_r, tx_wptr_nxt;
    logic [5:0]             tx_rptr_r, tx_rptr_nxt;
    logic                   tx_user_r, tx_user_nxt;
    logic [31:0]            tx_hdr_r, tx_hdr_nxt;
    logic [42:0]            tx_scr_r, tx_scr_nxt;
    cell_convergence_sublayer_pkg::line_byte_s tx_out_r, tx_out_nxt;
    logic                   tx_wr;
    logic [5:0]             tx_widx;
    logic                   tx_use;
    logic [7:0]             tx_pay;
    logic [7:0]             tx_hec;
    logic [31:0]            idle_hdr;

    assign idle_hdr = `IDLE_HDR;

    // check byte over all four header bytes
    hec_calc u_tx_hec (
        .i_hdr (tx_hdr_r),
        .o_hec (tx_hec)
    );

    always_comb
    begin
        tx_full_nxt = tx_full_r;
        tx_wptr_nxt = tx_wptr_r;
        tx_rptr_nxt = tx_rptr_r;
        tx_user_nxt = tx_user_r;
        tx_hdr_nxt  = tx_hdr_r;
        tx_scr_nxt  = tx_scr_r;
        tx_out_nxt  = '{valid: 1'b0, data: tx_out_r.data};
        tx_wr       = 1'b0;
        tx_widx     = tx_wptr_r;
        tx_use      = tx_user_r;
        tx_pay      = `IDLE_PAYLOAD;
        // cell taken only while space was offered
        if (i_tx.valid && !tx_full_r)
        begin
            if (i_tx.soc)
            begin
                tx_wr       = 1'b1;
                tx_widx     = 6'h00;
                tx_wptr_nxt = 6'h01;
            end
            else if (tx_wptr_r != 6'h00)
            begin
                tx_wr = 1'b1;
                if (tx_wptr_r == 6'(`LAST_POS))
                begin
                    tx_full_nxt = 1'b1;
                    tx_wptr_nxt = 6'h00;
                end
                else
                    tx_wptr_nxt = tx_wptr_r + 6'h01;
            end
        end
        // one byte per slot request, cells back to back
        if (i_line_tx_req)
        begin
            // no full cell at a boundary means an idle cell
            if (tx_rptr_r == 6'h00)
                tx_use = tx_full_r;
            tx_user_nxt = tx_use;
            tx_out_nxt.valid = 1'b1;
            if (tx_rptr_r < 6'(`HDR_LEN))
            begin
                tx_out_nxt.data = tx_use ? tx_mem[tx_rptr_r]
                                         : idle_hdr[31 - 8*tx_rptr_r[1:0] -: 8];
                tx_hdr_nxt = {tx_hdr_r[23:0], tx_out_nxt.data};
            end
            else if (tx_rptr_r == 6'(`HEC_POS))
                // computed check byte replaces the slot
                tx_out_nxt.data = tx_hec;
            else
            begin
                if (tx_use)
                    tx_pay = tx_mem[tx_rptr_r];
                {tx_scr_nxt, tx_out_nxt.data} = scr8(tx_scr_r, tx_pay, 1'b0);
            end
            // no frame alignment, the pointer runs free of frames
            if (tx_rptr_r == 6'(`LAST_POS))
            begin
                tx_rptr_nxt = 6'h00;
                if (tx_use)
                    tx_full_nxt = 1'b0;
            end
            else
                tx_rptr_nxt = tx_rptr_r + 6'h01;
        end
        tx_clav_nxt = !tx_full_nxt;
    end

    always_ff @(posedge i_mclk)
    begin
        if (tx_wr)
            tx_mem[tx_widx] <= i_tx.data;
        if (i_srst)
        begin
            tx_full_r <= 1'b0;
            tx_clav_r <= 1'b1;
            tx_wptr_r <= 6'h00;
            tx_rptr_r <= 6'h00;
            tx_user_r <= 1'b0;
            tx_hdr_r  <= 32'h00000000;
            tx_scr_r  <= 43'h0;
            tx_out_r  <= '0;
        end
        else
        begin
            tx_full_r <= tx_full_nxt;
            tx_clav_r <= tx_clav_nxt;
            tx_wptr_r <= tx_wptr_nxt;
            tx_rptr_r <= tx_rptr_nxt;
            tx_user_r <= tx_user_nxt;
            tx_hdr_r  <= tx_hdr_nxt;
            tx_scr_r  <= tx_scr_nxt;
            tx_out_r  <= tx_out_nxt;
        end
    end

    // space offered only when a whole cell fits
    assign o_tx_clav = tx_clav_r;
    assign o_line_tx = tx_out_r;

    // ----------------------------------------------------------------
    // receive path and delineation
    // ----------------------------------------------------------------
    logic [7:0]            rx_mem [0:`LAST_POS];
    cell_convergence_sublayer_pkg::delin_e    rx_st_r, rx_st_nxt;
    logic [5:0]            rx_pos_r, rx_pos_nxt;
    logic [2:0]            rx_cnt_r, rx_cnt_nxt;
    logic [31:0]           rx_sh_r, rx_sh_nxt;
    logic [42:0]           rx_dsc_r, rx_dsc_nxt;
    logic                  rx_wok_r, rx_wok_nxt;
    logic                  rx_keep_r, rx_keep_nxt;
    logic                  rx_full_r, rx_full_nxt;
    logic [5:0]            rx_rptr_r, rx_rptr_nxt;
    logic                  rx_err_r, rx_err_nxt;
    cell_convergence_sublayer_pkg::atm_byte_s rx_out_r, rx_out_nxt;
    logic                  rx_wr;
    logic [7:0]            rx_wdat;
    logic [7:0]            rx_hec;
    logic                  rx_hec_ok;

    hec_calc u_rx_hec (
        .i_hdr (rx_sh_r),
        .o_hec (rx_hec)
    );

    // exact match only; no single bit correction is tried
    assign rx_hec_ok = (rx_hec == i_line_rx.data);

    always_comb
    begin
        rx_st_nxt   = rx_st_r;
        rx_pos_nxt  = rx_pos_r;
        rx_cnt_nxt  = rx_cnt_r;
        rx_sh_nxt   = rx_sh_r;
        rx_dsc_nxt  = rx_dsc_r;
        rx_wok_nxt  = rx_wok_r;
        rx_keep_nxt = rx_keep_r;
        rx_full_nxt = rx_full_r;
        rx_rptr_nxt = rx_rptr_r;
        rx_err_nxt  = 1'b0;
        rx_out_nxt  = '{valid: 1'b0, soc: 1'b0, data: rx_out_r.data};
        rx_wr       = 1'b0;
        rx_wdat     = i_line_rx.data;
        // burst starts only after cell available was shown
        if (rx_full_r && (i_rx_enb || rx_rptr_r != 6'h00))
        begin
            rx_out_nxt = '{valid: 1'b1, soc: rx_rptr_r == 6'h00,
                           data: rx_mem[rx_rptr_r]};
            if (rx_rptr_r == 6'(`LAST_POS))
            begin
                rx_rptr_nxt = 6'h00;
                rx_full_nxt = 1'b0;
            end
            else
                rx_rptr_nxt = rx_rptr_r + 6'h01;
        end
        // bytes arrive already assembled msb first
        if (i_line_rx.valid)
        begin
            rx_sh_nxt = {rx_sh_r[23:0], i_line_rx.data};
            case (rx_st_r)
                cell_convergence_sublayer_pkg::ST_HUNT:
                begin
                    if (rx_hec_ok)
                    begin
                        rx_st_nxt   = cell_convergence_sublayer_pkg::ST_PRESYNC;
                        rx_cnt_nxt  = 3'h0;
                        rx_pos_nxt  = 6'(`HEC_POS + 1);
                        rx_wok_nxt  = 1'b0;
                        rx_keep_nxt = 1'b0;
                    end
                end
                default:
                begin
                    if (rx_pos_r == 6'h00)
                        rx_wok_nxt = !rx_full_r;
                    rx_wr = rx_wok_nxt;
                    if (rx_pos_r > 6'(`HEC_POS))
                        {rx_dsc_nxt, rx_wdat} = scr8(rx_dsc_r, i_line_rx.data, 1'b1);
                    if (rx_pos_r == 6'(`HEC_POS))
                    begin
                        if (rx_hec_ok)
                        begin
                            rx_keep_nxt = rx_wok_nxt && rx_sh_r != `IDLE_HDR
                                          && rx_st_r == cell_convergence_sublayer_pkg::ST_SYNC;
                            rx_cnt_nxt = rx_cnt_r + 3'h1;
                            if (rx_st_r == cell_convergence_sublayer_pkg::ST_SYNC)
                                rx_cnt_nxt = 3'h0;
                            else if (rx_cnt_r == 3'(`DELIN_DELTA - 1))
                            begin
                                rx_st_nxt  = cell_convergence_sublayer_pkg::ST_SYNC;
                                rx_cnt_nxt = 3'h0;
                            end
                        end
                        else
                        begin
                            rx_err_nxt  = 1'b1;
                            rx_keep_nxt = 1'b0;
                            rx_cnt_nxt  = rx_cnt_r + 3'h1;
                            if (rx_st_r == cell_convergence_sublayer_pkg::ST_PRESYNC
                                || rx_cnt_r == 3'(`DELIN_ALPHA - 1))
                            begin
                                rx_st_nxt  = cell_convergence_sublayer_pkg::ST_HUNT;
                                rx_cnt_nxt = 3'h0;
                            end
                        end
                    end
                    if (rx_pos_r == 6'(`LAST_POS))
                    begin
                        rx_pos_nxt = 6'h00;
                        // set after the clear, a whole kept cell
                        if (rx_keep_r)
                            rx_full_nxt = 1'b1;
                    end
                    else
                        rx_pos_nxt = rx_pos_r + 6'h01;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (rx_wr)
            rx_mem[rx_pos_r] <= rx_wdat;
        if (i_srst)
        begin
            rx_st_r   <= cell_convergence_sublayer_pkg::ST_HUNT;
            rx_pos_r  <= 6'h00;
            rx_cnt_r  <= 3'h0;
            rx_sh_r   <= 32'h00000000;
            rx_dsc_r  <= 43'h0;
            rx_wok_r  <= 1'b0;
            rx_keep_r <= 1'b0;
            rx_full_r <= 1'b0;
            rx_rptr_r <= 6'h00;
            rx_err_r  <= 1'b0;
            rx_out_r  <= '0;
            o_cell_sync <= 1'b0;
        end
        else
        begin
            rx_st_r   <= rx_st_nxt;
            rx_pos_r  <= rx_pos_nxt;
            rx_cnt_r  <= rx_cnt_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_dsc_r  <= rx_dsc_nxt;
            rx_wok_r  <= rx_wok_nxt;
            rx_keep_r <= rx_keep_nxt;
            rx_full_r <= rx_full_nxt;
            rx_rptr_r <= rx_rptr_nxt;
            rx_err_r  <= rx_err_nxt;
            rx_out_r  <= rx_out_nxt;
            o_cell_sync <= rx_st_nxt == cell_convergence_sublayer_pkg::ST_SYNC;
        end
    end

    assign o_rx_clav = rx_full_r;
    assign o_rx      = rx_out_r;
    assign o_hec_err = rx_err_r;

    // ----------------------------------------------------------------
    // timing reference and frame geometry
    // ----------------------------------------------------------------
    logic        ref_d_r, ref_d_nxt;
    logic [8:0]  ref_cnt_r, ref_cnt_nxt;
    logic [12:0] ntr_cnt_r, ntr_cnt_nxt;
    logic [5:0]  ntr_part_r, ntr_part_nxt;
    logic        tref_r, tref_nxt;
    logic        rref_r, rref_nxt;
    logic        stuff_r, stuff_nxt;
    logic        cfg_bad_r, cfg_bad_nxt;
    logic [13:0] fbits_r, fbits_nxt;
    logic [8:0]  ref_div;

    always_comb
    begin
        ref_d_nxt    = i_ref_clk;
        ref_cnt_nxt  = ref_cnt_r;
        ntr_cnt_nxt  = ntr_cnt_r + 13'h1;
        ntr_part_nxt = ntr_part_r;
        tref_nxt     = 1'b0;
        rref_nxt     = 1'b0;
        // selected reference divided down to 8 khz
        case (i_ref_sel)
            2'h0:    ref_div = 9'(`DIV_8K);
            2'h1:    ref_div = 9'(`DIV_64K);
            2'h2:    ref_div = 9'(`DIV_1544K);
            default: ref_div = 9'(`DIV_2048K);
        endcase
        if (i_ref_clk && !ref_d_r)
        begin
            if (ref_cnt_r >= ref_div - 9'h1)
            begin
                ref_cnt_nxt = 9'h000;
                // line end passes 8 khz toward the framing
                tref_nxt = i_ltu_side;
            end
            else
                ref_cnt_nxt = ref_cnt_r + 9'h1;
        end
        // 48 ticks of 125 us, restarted by each frame sync word
        if (i_frame_sync)
        begin
            ntr_cnt_nxt  = 13'h0;
            ntr_part_nxt = 6'h00;
            rref_nxt     = !i_ltu_side;
        end
        else if (ntr_cnt_r >= 13'(NTR_CYCLES - 1))
        begin
            ntr_cnt_nxt = 13'h0;
            // fixed frame, never more than 48 ticks per frame
            if (ntr_part_r < 6'(`NTR_PARTS - 1))
            begin
                ntr_part_nxt = ntr_part_r + 6'h01;
                // network end passes 8 khz toward the atm layer
                rref_nxt     = !i_ltu_side;
            end
        end
        // stuffing off when the frame must lock to the reference
        stuff_nxt = i_ltu_side && i_ntr_required;
        // n byte slots must be 3 to 36
        // n and i count 64 and 8 kbit/s channels
        cfg_bad_nxt = i_cfg_n < 6'(`N_MIN) || i_cfg_n > 6'(`N_MAX);
        fbits_nxt = 14'(`NTR_PARTS * (1 + int'(i_cfg_i) + 8 * int'(i_cfg_n)));
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            ref_d_r    <= 1'b0;
            ref_cnt_r  <= 9'h000;
            ntr_cnt_r  <= 13'h0;
            ntr_part_r <= 6'h00;
            tref_r     <= 1'b0;
            rref_r     <= 1'b0;
            stuff_r    <= 1'b0;
            cfg_bad_r  <= 1'b0;
            fbits_r    <= 14'h0;
        end
        else
        begin
            ref_d_r    <= ref_d_nxt;
            ref_cnt_r  <= ref_cnt_nxt;
            ntr_cnt_r  <= ntr_cnt_nxt;
            ntr_part_r <= ntr_part_nxt;
            tref_r     <= tref_nxt;
            rref_r     <= rref_nxt;
            stuff_r    <= stuff_nxt;
            cfg_bad_r  <= cfg_bad_nxt;
            fbits_r    <= fbits_nxt;
        end
    end

    assign o_transmit_timing_ref_line = tref_r;
    assign o_receive_timing_ref_line  = rref_r;
    assign o_stuffing_off             = stuff_r;
    assign o_cfg_bad                  = cfg_bad_r;
    assign o_frame_bits               = fbits_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    tx_clav_a: assert property (i_tx.valid && !i_tx.soc && !tx_full_r
        && tx_wptr_r == 6'(`LAST_POS) |=> !o_tx_clav ##1 !o_tx_clav)
        else $error("cell available not dropped after a full cell");
    tx_slot_a: assert property (i_line_tx_req |=> o_line_tx.valid)
        else $error("slot request without a byte");
    tx_hec_a: assert property (i_line_tx_req && tx_rptr_r == 6'(`HEC_POS)
        |=> o_line_tx.data == $past(tx_hec))
        else $error("check byte not sent at byte four");
    tx_idle_a: assert property (i_line_tx_req && tx_rptr_r == 6'h00
        && !tx_full_r |=> o_line_tx.data == 8'h00)
        else $error("idle cell header not inserted");
    rx_idle_a: assert property ($rose(rx_keep_r) |-> $past(rx_sh_r) != `IDLE_HDR)
        else $error("idle cell kept for delivery");
    rx_clav_a: assert property (o_rx.valid && o_rx.soc |-> $past(o_rx_clav, 1))
        else $error("cell delivered without cell available");
    rx_burst_a: assert property (o_rx.valid && o_rx.soc |=> o_rx.valid [*8])
        else $error("receive cell not continuous");
    hec_err_a: assert property (o_hec_err |-> $past(i_line_rx.valid)
        && $past(rx_st_r) != cell_convergence_sublayer_pkg::ST_HUNT)
        else $error("error pulse without a checked header");
    stuff_a: assert property (o_stuffing_off |-> $past(i_ltu_side && i_ntr_required))
        else $error("stuffing off without a timing need");
    rref_a: assert property (o_receive_timing_ref_line |=> !o_receive_timing_ref_line)
        else $error("timing tick longer than one cycle");

    user_cell_c: cover property (i_line_tx_req && tx_rptr_r == 6'h00 && tx_full_r);
    sync_c:      cover property (rx_st_r == cell_convergence_sublayer_pkg::ST_SYNC);
    deliver_c:   cover property (o_rx.valid && o_rx.soc);
    hec_err_c:   cover property (o_hec_err);

endmodule

`default_nettype wire

// *** bench/line_partner.sv ***
// line framing sublayer model: paces payload byte requests and loops bytes back
`timescale 1ns/1ps
`default_nettype none

module line_partner (
    input  wire logic                   i_mclk,
    input  wire logic                   i_srst,
    input  wire cell_convergence_sublayer_pkg::line_byte_s i_tx,
    input  wire logic                   i_flip,
    output logic                        o_req,
    output cell_convergence_sublayer_pkg::line_byte_s      o_rx
);
    logic [1:0] cnt_r;

    // one byte slot every four cycles, no frame alignment
    always_ff @(posedge i_mclk)
    begin
        cnt_r      <= i_srst ? 2'h0 : cnt_r + 2'h1;
        o_req      <= !i_srst && cnt_r == 2'h2;
        o_rx.valid <= !i_srst && i_tx.valid;
        // released line shows the inverse, so stale data cannot pass for a byte
        // a set flip corrupts bit 0 of every byte that passes
        o_rx.data  <= i_tx.valid ? i_tx.data ^ {7'h00, i_flip} : ~o_rx.data;
    end
endmodule

`default_nettype wire

// *** bench/atm_cell_convergence_sdsl_tb.sv ***
// loopback bench: cells go out on the line, come back and reach the atm side
`timescale 1ns/1ps
`default_nettype none

module atm_cell_convergence_sdsl_tb;
    logic                   i_mclk = 1'b0;
    logic                   i_srst = 1'b1;
    logic                   i_rx_enb = 1'b0;
    logic                   i_ref_clk = 1'b0;
    logic                   i_frame_sync = 1'b0;
    logic                   flip = 1'b0;
    logic                   i_ltu_side, i_ntr_required, i_line_tx_req;
    logic                   o_tx_clav, o_rx_clav, o_hec_err, o_cell_sync;
    logic                   o_cfg_bad, o_stuffing_off, tx_ref, rx_ref;
    logic [5:0]             i_cfg_n;
    logic [2:0]             i_cfg_i;
    logic [13:0]            o_frame_bits;
    cell_convergence_sublayer_pkg::ref_sel_t   i_ref_sel;
    cell_convergence_sublayer_pkg::atm_byte_s  i_tx, o_rx;
    cell_convergence_sublayer_pkg::line_byte_s o_line_tx, i_line_rx;
    logic [31:0]            hdr;
    logic [7:0]             v;
    logic [7:0]             exp_q[$];
    int                     seed, n_mismatch, checks, n_rx, nv, iv;
    int                     n_err, gap, div, phase, seen, fcnt;

    atm_cell_convergence #(.NTR_CYCLES(20)) dut (.i_mclk, .i_srst, .i_tx, .o_tx_clav,
        .i_rx_enb, .o_rx, .o_rx_clav, .i_line_tx_req, .o_line_tx, .i_line_rx, .o_hec_err,
        .o_cell_sync, .i_ltu_side, .i_ntr_required, .i_ref_clk, .i_ref_sel, .i_frame_sync,
        .i_cfg_n, .i_cfg_i, .o_stuffing_off, .o_transmit_timing_ref_line(tx_ref),
        .o_receive_timing_ref_line(rx_ref), .o_cfg_bad, .o_frame_bits);
    line_partner far (.i_mclk, .i_srst, .i_tx(o_line_tx), .i_flip(flip), .o_req(i_line_tx_req),
        .o_rx(i_line_rx));

    always #12.5 i_mclk = ~i_mclk;

    function automatic logic [7:0] crc8(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 31; k >= 0; k--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[k]) ? 8'h07 : 8'h00);
        return c ^ 8'h55;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(negedge i_mclk)
    begin
        i_ref_clk <= ~i_ref_clk;
        // frame sync every 48 ticks of the shortened counter, as on a real line
        i_frame_sync <= fcnt % 960 == 0;
        fcnt++;
        gap++;
        if (o_hec_err === 1'b1)
            n_err++;
        if (o_cell_sync === 1'b1 && phase < 2)
            chk("hec_err", 16'h0, 16'(o_hec_err));
        if ((phase == 1 && tx_ref === 1'b1) || (phase == 2 && rx_ref === 1'b1))
        begin
            if (seen)
                chk("ref_gap", 16'(phase == 1 ? 2 * div : 20), 16'(gap));
            seen = 1;
            gap = 0;
        end
    end

    // receive side: take each announced cell and compare it byte by byte
    initial
    forever
    begin
        @(negedge i_mclk);
        if (o_rx_clav === 1'b1)
        begin
            i_rx_enb = 1'b1;
            // first byte stands one edge after the request is taken
            for (int b = 0; b < 53; b++)
            begin
                @(negedge i_mclk);
                i_rx_enb = 1'b0;
                chk("rx_vs", 16'({1'b1, b == 0}), 16'({o_rx.valid, o_rx.soc}));
                chk("rx_data", 16'(exp_q.pop_front()), 16'(o_rx.data));
            end
            n_rx++;
        end
    end

    initial
    begin
        repeat (40000) @(posedge i_mclk);
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        seed = 32'ha629;
        {i_ltu_side, i_ntr_required, i_tx, i_ref_sel, i_cfg_n, i_cfg_i} = '0;
        repeat (8) @(negedge i_mclk);
        i_srst = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            {i_ltu_side, i_ntr_required} = 2'(k);
            repeat (2) @(negedge i_mclk);
            chk("stuff_off", 16'(k == 3), 16'(o_stuffing_off));
        end
        repeat (16)
        begin
            nv = $random(seed) & 63;
            iv = $random(seed) & 7;
            {i_cfg_n, i_cfg_i, i_ref_sel} = {6'(nv), 3'(iv), 2'(nv)};
            repeat (2) @(negedge i_mclk);
            chk("cfg_bad", 16'(nv < 3 || nv > 36), 16'(o_cfg_bad));
            if (nv >= 3 && nv <= 36)
                chk("frame_bits", 16'(48 * (1 + iv + 8 * nv)), 16'(o_frame_bits));
        end
        // line end from here on: reference divided to 8 khz, two mclk per ref period
        div = i_ref_sel == 2'h0 ? 1 : i_ref_sel == 2'h1 ? 8 : i_ref_sel == 2'h2 ? 193 : 256;
        phase = 1;
        // idle fill alone must bring delineation to sync
        for (int t = 0; t < 30000 && o_cell_sync !== 1'b1; t++) @(negedge i_mclk);
        chk("cell_sync", 16'h1, 16'(o_cell_sync));
        for (int c = 0; c < 4; c++)
        begin
            // send only while space is offered
            for (int t = 0; t < 3000 && o_tx_clav !== 1'b1; t++) @(negedge i_mclk);
            hdr = $random(seed) | 32'h10000000;
            for (int b = 0; b < 53; b++)
            begin
                v = b < 4 ? hdr[31 - 8 * b -: 8] : 8'($random(seed));
                exp_q.push_back(b == 4 ? crc8(hdr) : v);
                i_tx = '{1'b1, b == 0, v};
                @(negedge i_mclk);
            end
            i_tx = '0;
            repeat (2) @(negedge i_mclk);
        end
        for (int t = 0; t < 5000 && n_rx < 4; t++) @(negedge i_mclk);
        chk("cells", 16'h4, 16'(n_rx));
        // network end; 49 corrupted line bytes always cover exactly one header
        i_ltu_side = 1'b0;
        seen = 0;
        n_err = 0;
        phase = 2;
        flip = 1'b1;
        repeat (196) @(negedge i_mclk);
        flip = 1'b0;
        repeat (404) @(negedge i_mclk);
        chk("hec_errs", 16'h1, 16'(n_err));
        finish_test;
    end
endmodule

`default_nettype wire
